// ### hw/ispf_pkg.sv
// Constants, types and the register map of the boot-region flash program/erase controller.
// Assumes one 100 MHz clock, APB register access and an external flash array macro.
// Operation
// - Lock key register resets to C9, read/write.
// - Data memory writes only while lock holds C9.
// - Lock key persists; no rewrite per write.
// - Shared array: no access during program/erase.
// - Boot region E000-E5FF; boot mode starts E000.
// - A1 column, A[11:2] row; 384 rows boot.
// - 192 pages of 4 words; page erase, row program.
// - Zero wait states, or one at high clock.
// - Sense amp enable depends on power mode.
// - No program or erase without valid key; data memory writes need only the lock.
// - Mass and odd/even erase only in test mode.
// - Busy flag set during operation, blocks access.
// - Reset aborts operation; held until array idle.
// - Pulses: 30us program, 1ms page, 4ms mass.
// - Config bytes loaded from array during reset.
// - Empty-code byte write protection by environment.
// - Config byte: code region high bits, empty code.
// - Empty when two code bits set; boot mode.
// - Page erase bit turns write into page erase.
package ispf_pkg;
	// Timing.
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_NS = 30000;
	localparam int PAGE_ERASE_TIME_NS = 1000000;
	localparam int MASS_ERASE_TIME_NS = 4000000;
	localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PAGE_ERASE_CYC = (PAGE_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MASS_ERASE_CYC = (MASS_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_W = 20;
	// Address map of the shared array.
	localparam logic [15:0] ISP_BASE = 16'hE000;
	localparam logic [15:0] ARRAY_LAST = 16'hEFFF;
	localparam logic [9:0] ISP_ROWS = 10'h180;
	localparam logic [11:0] CFG_HI_ADDR = 12'h5FE;
	localparam logic [11:0] CFG_LO_ADDR = 12'h5FC;
	localparam logic [15:0] ISP_VECTOR = 16'hE000;
	localparam logic [6:0] BOOT_AREA_OFF = 7'h7F;
	localparam logic [16:0] BOOT_TAIL_BYTES = 17'h00004;
	localparam logic [2:0] ENV_ALL_HIGH = 3'h7;
	localparam logic [1:0] BE_WORD = 2'h3;
	// Key and reset values.
	localparam logic [7:0] DM_UNLOCK = 8'hC9;
	localparam logic [7:0] LOCK_RST = 8'hC9;
	localparam logic [15:0] CFG2_RST = 16'h0000;
	localparam logic [7:0] CFG1_RST = 8'h00;
	localparam logic [7:0] SEC_RST = 8'h00;
	localparam logic [3:0] CTRL_RST = 4'h0;
	// Register byte offsets.
	localparam logic [7:0] OFS_LOCK = 8'h00;
	localparam logic [7:0] OFS_PKEY = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_CFG2 = 8'h10;
	localparam logic [7:0] OFS_CFG1 = 8'h14;
	localparam logic [7:0] OFS_SEC = 8'h18;
	// Control fields.
	localparam int CTRL_ERASE = 0;
	localparam int CTRL_MASS_ERASE_SELECT = 1;
	localparam int CTRL_HIGH_POWER_FLASH_MODE = 2;
	localparam int CTRL_WAIT = 3;
	// Second config word fields.
	localparam int EMPTY_HI = 15;
	localparam int EMPTY_LO = 13;

	typedef enum logic [2:0] {
		ST_WAIT_IDLE = 3'h0,
		ST_LD_HI = 3'h1,
		ST_LD_LO = 3'h3,
		ST_RUN = 3'h2
	} ispf_state_e;

	typedef struct packed {
		logic prog;
		logic page_erase;
		logic mass_erase;
		logic half_erase;
		logic rd;
		logic sa_en;
		logic sa_half;
	} ispf_arr_ctl_s;
endpackage

// ### hw/ispf_ctrl.sv
// Boot-region flash program/erase controller: APB registers, CPU memory port, array sequencer.
// Assumes an array macro with combinational read data while rd is high and an idle indication.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module ispf_ctrl #(
	parameter int PAGE_ERASE_CYC = ispf_pkg::PAGE_ERASE_CYC,
	parameter int MASS_ERASE_CYC = ispf_pkg::MASS_ERASE_CYC,
	// Program key value is arbitrary.
	parameter logic [7:0] PROG_KEY = 8'h5A,
	parameter logic [15:0] IRE_VECTOR = 16'h0000
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// CPU memory port
	input wire logic mem_sel,
	input wire logic mem_wr,
	input wire logic [15:0] mem_addr,
	input wire logic [1:0] mem_be,
	input wire logic [15:0] mem_wdata,
	input wire logic [15:0] exec_addr,
	output logic mem_ready,
	output logic mem_err,
	output logic [15:0] mem_rdata,
	// Flash array macro
	output logic [11:0] arr_addr,
	output logic [15:0] arr_wdata,
	output logic [1:0] arr_be,
	output ispf_pkg::ispf_arr_ctl_s arr_ctl,
	input wire logic [15:0] arr_rdata,
	input wire logic arr_idle,
	// Environment
	input wire logic [2:0] env_sel,
	input wire logic test_mode,
	output logic cpu_rst_b,
	output logic isp_env,
	output logic [15:0] boot_vector
);
	ispf_pkg::ispf_state_e state_r;
	logic ld_ph_r;
	logic rd_act_r;
	logic rd_ph_r;
	logic busy_r;
	logic [ispf_pkg::PULSE_W-1:0] pulse_cnt_r;
	logic [ispf_pkg::PULSE_W-1:0] hlp_len_r;
	logic [7:0] lock_r;
	logic key_armed_r;
	logic [3:0] ctrl_r;
	logic [15:0] cfg2_r;
	logic [7:0] cfg1_r;
	logic [7:0] sec_r;

	// APB decode.
	wire logic apb_setup = psel & ~penable;
	wire logic apb_wr = psel & penable & pready & pwrite;
	wire logic sel_lock = paddr == ispf_pkg::OFS_LOCK;
	wire logic sel_pkey = paddr == ispf_pkg::OFS_PKEY;
	wire logic sel_ctrl = paddr == ispf_pkg::OFS_CTRL;
	wire logic sel_stat = paddr == ispf_pkg::OFS_STAT;
	wire logic sel_cfg2 = paddr == ispf_pkg::OFS_CFG2;
	wire logic sel_cfg1 = paddr == ispf_pkg::OFS_CFG1;
	wire logic sel_sec = paddr == ispf_pkg::OFS_SEC;
	wire logic apb_mapped = sel_lock | sel_pkey | sel_ctrl | sel_stat | sel_cfg2 | sel_cfg1
		| sel_sec;
	wire logic empty_code = (cfg2_r[ispf_pkg::EMPTY_HI] & cfg2_r[ispf_pkg::EMPTY_HI-1])
		| (cfg2_r[ispf_pkg::EMPTY_HI] & cfg2_r[ispf_pkg::EMPTY_LO])
		| (cfg2_r[ispf_pkg::EMPTY_HI-1] & cfg2_r[ispf_pkg::EMPTY_LO]);
	wire logic [3:0] stat_word = {empty_code, isp_env, key_armed_r, busy_r};
	wire logic [31:0] rd_mux = sel_lock ? {24'h000000, lock_r}
		: sel_ctrl ? {28'h0000000, ctrl_r}
		: sel_stat ? {28'h0000000, stat_word}
		: sel_cfg2 ? {16'h0000, cfg2_r}
		: sel_cfg1 ? {24'h000000, cfg1_r}
		: sel_sec ? {24'h000000, sec_r}
		: 32'h00000000;

	// Memory port decode.
	wire logic [9:0] mem_row = mem_addr[11:2];
	wire logic in_array = (mem_addr >= ispf_pkg::ISP_BASE) && (mem_addr <= ispf_pkg::ARRAY_LAST);
	wire logic in_isp = in_array && (mem_row < ispf_pkg::ISP_ROWS);
	wire logic acc_new = mem_sel & ~mem_ready & ~rd_act_r & (state_r == ispf_pkg::ST_RUN);
	wire logic refuse = acc_new & (busy_r | ~in_array);
	wire logic rd_go = acc_new & ~refuse & ~mem_wr;
	wire logic wr_go = acc_new & ~refuse & mem_wr;
	wire logic word_wr = mem_be == ispf_pkg::BE_WORD;
	wire logic high_power_flash_mode = ctrl_r[ispf_pkg::CTRL_HIGH_POWER_FLASH_MODE];
	wire logic wait_en = ctrl_r[ispf_pkg::CTRL_WAIT];
	wire logic rd_done = rd_act_r & ~(wait_en & ~rd_ph_r);

	// The empty-code byte is guarded so that a stray write from the boot area's own tail
	// cannot brick the start-up selection.
	wire logic [13:0] boot_end = {cfg1_r[6:0], 7'h7F};
	wire logic boot_en = cfg1_r[6:0] != ispf_pkg::BOOT_AREA_OFF;
	wire logic [16:0] exec_lim = {1'b0, exec_addr} + ispf_pkg::BOOT_TAIL_BYTES;
	wire logic exec_ok = exec_lim <= {3'h0, boot_end};
	wire logic cfg_hit = in_isp && (mem_addr[11:1] == ispf_pkg::CFG_HI_ADDR[11:1]);
	wire logic cfg_ok = ~cfg_hit | isp_env | test_mode
		| (~word_wr & boot_en & exec_ok);

	// Operation selection.
	wire logic mass_mode = ctrl_r[ispf_pkg::CTRL_MASS_ERASE_SELECT];
	wire logic page_mode = ctrl_r[ispf_pkg::CTRL_ERASE] & ~mass_mode;
	wire logic isp_wr_ok = key_armed_r & cfg_ok & (~mass_mode | test_mode);
	wire logic dm_wr_ok = lock_r == ispf_pkg::DM_UNLOCK;
	wire logic op_start = wr_go & (in_isp ? isp_wr_ok : dm_wr_ok);
	wire logic op_mass = in_isp & mass_mode & word_wr;
	wire logic op_half = in_isp & mass_mode & ~word_wr;
	wire logic op_page = in_isp & page_mode;
	wire logic op_prog = ~op_mass & ~op_half & ~op_page;
	wire logic [ispf_pkg::PULSE_W-1:0] pulse_last = (op_mass | op_half)
		? ispf_pkg::PULSE_W'(MASS_ERASE_CYC - 1)
		: op_page ? ispf_pkg::PULSE_W'(PAGE_ERASE_CYC - 1)
		: ispf_pkg::PULSE_W'(ispf_pkg::PROG_CYC - 1);

	// APB answers one cycle after setup, so every transfer has exactly one access cycle.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_setup;
			prdata <= apb_setup ? rd_mux : 32'h00000000;
			pslverr <= apb_setup & ~apb_mapped;
		end
	end

	// Software registers.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_r <= ispf_pkg::LOCK_RST;
			ctrl_r <= ispf_pkg::CTRL_RST;
			key_armed_r <= 1'b0;
		end else begin
			if (apb_wr && sel_lock) begin
				lock_r <= pwdata[7:0];
			end
			if (apb_wr && sel_ctrl) begin
				ctrl_r <= pwdata[3:0];
			end
			// The key is consumed by the next boot-region write, valid or not.
			if (wr_go && in_isp) begin
				key_armed_r <= 1'b0;
			end else if (apb_wr && sel_pkey) begin
				key_armed_r <= pwdata[7:0] == PROG_KEY;
			end
		end
	end

	// CPU memory port answers.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_ready <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= 16'h0000;
		end else begin
			mem_ready <= refuse | wr_go | rd_done;
			mem_err <= refuse | (wr_go & ~op_start);
			if (rd_done) begin
				mem_rdata <= arr_rdata;
			end else if (refuse) begin
				mem_rdata <= 16'h0000;
			end
		end
	end

	// Array sequencer: start-up loading, reads and program/erase pulses.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ispf_pkg::ST_WAIT_IDLE;
			ld_ph_r <= 1'b0;
			rd_act_r <= 1'b0;
			rd_ph_r <= 1'b0;
			busy_r <= 1'b0;
			pulse_cnt_r <= '0;
			arr_addr <= 12'h000;
			arr_wdata <= 16'h0000;
			arr_be <= 2'h0;
			arr_ctl <= '0;
			cfg2_r <= ispf_pkg::CFG2_RST;
			cfg1_r <= ispf_pkg::CFG1_RST;
			sec_r <= ispf_pkg::SEC_RST;
			cpu_rst_b <= 1'b0;
			isp_env <= 1'b0;
			boot_vector <= IRE_VECTOR;
		end else begin
			unique case (state_r)
				ispf_pkg::ST_WAIT_IDLE: begin
					// An aborted pulse may still be settling; loading waits for it.
					if (arr_idle) begin
						state_r <= ispf_pkg::ST_LD_HI;
					end
				end
				ispf_pkg::ST_LD_HI, ispf_pkg::ST_LD_LO: begin
					if (!ld_ph_r) begin
						arr_addr <= (state_r == ispf_pkg::ST_LD_HI) ? ispf_pkg::CFG_HI_ADDR
							: ispf_pkg::CFG_LO_ADDR;
						arr_ctl.rd <= 1'b1;
						arr_ctl.sa_en <= 1'b1;
						ld_ph_r <= 1'b1;
					end else begin
						arr_ctl <= '0;
						ld_ph_r <= 1'b0;
						if (state_r == ispf_pkg::ST_LD_HI) begin
							cfg2_r[15:8] <= arr_rdata[7:0];
							sec_r <= arr_rdata[15:8];
							state_r <= ispf_pkg::ST_LD_LO;
						end else begin
							cfg2_r[7:0] <= arr_rdata[7:0];
							cfg1_r <= arr_rdata[15:8];
							isp_env <= boot_empty_r(cfg2_r);
							boot_vector <= boot_empty_r(cfg2_r) ? ispf_pkg::ISP_VECTOR
								: IRE_VECTOR;
							cpu_rst_b <= 1'b1;
							state_r <= ispf_pkg::ST_RUN;
						end
					end
				end
				ispf_pkg::ST_RUN: begin
					if (busy_r) begin
						if (pulse_cnt_r == '0) begin
							busy_r <= 1'b0;
							arr_ctl <= '0;
						end else begin
							pulse_cnt_r <= pulse_cnt_r - 1'b1;
						end
					end else if (rd_act_r) begin
						if (!rd_done) begin
							rd_ph_r <= 1'b1;
							arr_ctl.sa_en <= 1'b1;
						end else begin
							rd_act_r <= 1'b0;
							rd_ph_r <= 1'b0;
							arr_ctl <= '0;
						end
					end else if (rd_go) begin
						arr_addr <= mem_addr[11:0];
						arr_ctl.rd <= 1'b1;
						arr_ctl.sa_en <= high_power_flash_mode;
						arr_ctl.sa_half <= ~high_power_flash_mode & ~wait_en;
						rd_act_r <= 1'b1;
					end else if (op_start) begin
						arr_addr <= mem_addr[11:0];
						arr_wdata <= mem_wdata;
						arr_be <= mem_be;
						arr_ctl.prog <= op_prog;
						arr_ctl.page_erase <= op_page;
						arr_ctl.mass_erase <= op_mass;
						arr_ctl.half_erase <= op_half;
						pulse_cnt_r <= pulse_last;
						busy_r <= 1'b1;
					end
				end
				default: begin
					state_r <= ispf_pkg::ST_WAIT_IDLE;
				end
			endcase
		end
	end

	// The empty decision uses the high config byte loaded one step earlier.
	function automatic logic boot_empty_r(input logic [15:0] c2);
		logic [2:0] e;
		e = c2[ispf_pkg::EMPTY_HI:ispf_pkg::EMPTY_LO];
		return (env_sel == ispf_pkg::ENV_ALL_HIGH) & ((e[2] & e[1]) | (e[2] & e[0])
			| (e[1] & e[0]));
	endfunction

	// Helper: length of the current programming strobe.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			hlp_len_r <= '0;
		end else begin
			hlp_len_r <= arr_ctl.prog ? hlp_len_r + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	property p_lock_steady;
		!(apb_wr && sel_lock) |=> $stable(lock_r);
	endproperty
	a_lock_steady: assert property (p_lock_steady) else $error("lock key changed without a write");

	property p_dm_locked;
		(wr_go && !in_isp && lock_r != ispf_pkg::DM_UNLOCK) |=> !busy_r ##0 mem_err;
	endproperty
	a_dm_locked: assert property (p_dm_locked) else $error("locked data write was not ignored");

	property p_keyless;
		(wr_go && in_isp && !key_armed_r) |=> !busy_r && mem_err && arr_ctl == '0;
	endproperty
	a_keyless: assert property (p_keyless) else $error("keyless write started an operation");

	property p_busy_refuse;
		(mem_sel && busy_r && acc_new) |=> mem_ready && mem_err && mem_rdata == 16'h0000;
	endproperty
	a_busy_refuse: assert property (p_busy_refuse) else $error("access during busy not refused");

	property p_busy_strobe;
		$rose(busy_r) |-> (arr_ctl.prog | arr_ctl.page_erase | arr_ctl.mass_erase
			| arr_ctl.half_erase);
	endproperty
	a_busy_strobe: assert property (p_busy_strobe) else $error("busy without array operation");

	property p_prog_len;
		$fell(arr_ctl.prog) |-> hlp_len_r == ispf_pkg::PULSE_W'(ispf_pkg::PROG_CYC);
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("program pulse length wrong");

	property p_zero_wait;
		(rd_go && !wait_en) |-> !mem_ready ##1 !mem_ready ##1 mem_ready;
	endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("zero wait read timing wrong");

	property p_one_wait;
		(rd_go && wait_en) |-> ##1 !mem_ready [*2] ##1 mem_ready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("one wait read timing wrong");

	property p_high_power_flash_mode_sa;
		(arr_ctl.rd && rd_act_r && high_power_flash_mode && $stable(ctrl_r)) |-> arr_ctl.sa_en;
	endproperty
	a_high_power_flash_mode_sa: assert property (p_high_power_flash_mode_sa) else $error("sense amp off in high power");

	property p_held_reset;
		(state_r != ispf_pkg::ST_RUN) |-> !cpu_rst_b && !mem_ready;
	endproperty
	a_held_reset: assert property (p_held_reset) else $error("cpu released before config load");

	property p_mass_test;
		$rose(arr_ctl.mass_erase | arr_ctl.half_erase) |-> $past(test_mode);
	endproperty
	a_mass_test: assert property (p_mass_test) else $error("mass erase outside test mode");
endmodule // ispf_ctrl

// ### bench/ispf_array_model.sv
// Behavioural model of the shared flash array macro that the controller drives.
// Assumes registered strobes from the controller on the one system clock.
`timescale 1ns/1ns
module ispf_array_model (
	// Clock
	input wire logic sys_clk,
	// Controller side
	input wire logic [11:0] arr_addr,
	input wire logic [15:0] arr_wdata,
	input wire logic [1:0] arr_be,
	input wire ispf_pkg::ispf_arr_ctl_s arr_ctl,
	output logic [15:0] arr_rdata,
	output logic arr_idle
);
	logic [15:0] cells [0:2047];
	logic [15:0] last_r;
	logic strobe_q;
	int run_len;
	int last_len;
	wire strobe = arr_ctl.prog | arr_ctl.page_erase | arr_ctl.mass_erase | arr_ctl.half_erase;
	wire [15:0] lane_mask = {{8{arr_be[1]}}, {8{arr_be[0]}}};
	wire [10:0] page_base = {arr_addr[11:3], 2'b00};
	// An idle bus shows the inverse of the last read, so a missing read strobe cannot pass.
	assign arr_rdata = arr_ctl.rd ? cells[arr_addr[11:1]] : ~last_r;
	assign arr_idle = !strobe;
	initial begin
		for (int i = 0; i < 2048; i++) begin
			cells[i] = 16'hFFFF;
		end
		last_r = 16'h0000;
		strobe_q = 1'b0;
		run_len = 0;
		last_len = 0;
	end
	always @(posedge sys_clk) begin
		strobe_q <= strobe;
		if (arr_ctl.rd) begin
			last_r <= arr_rdata;
		end
		run_len <= strobe ? run_len + 1 : 0;
		if (strobe_q && !strobe) begin
			last_len <= run_len;
		end
		if (strobe && !strobe_q) begin
			// Programming can only clear bits, so a cell must be erased first.
			if (arr_ctl.prog) begin
				cells[arr_addr[11:1]] <= cells[arr_addr[11:1]] & (arr_wdata | ~lane_mask);
			end
			for (int i = 0; i < 2048; i++) begin
				if (arr_ctl.page_erase && i[10:2] == page_base[10:2]) begin
					cells[i] <= 16'hFFFF;
				end
				if (arr_ctl.mass_erase) begin
					cells[i] <= 16'hFFFF;
				end
				if (arr_ctl.half_erase) begin
					cells[i] <= cells[i] | lane_mask;
				end
			end
		end
	end
endmodule // ispf_array_model

// ### bench/tb_top.sv
// Self-checking bench for the flash program/erase controller, APB and CPU port driven here.
// Assumes the array model beside the controller and short erase counts for simulation.
`timescale 1ns/1ns
module tb_top;
	localparam int PE_CYC = 20;
	localparam int ME_CYC = 40;
	// Program key value is arbitrary.
	localparam logic [7:0] KEY = 8'h5A;
	logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, mem_sel, mem_wr;
	logic mem_ready, mem_err, arr_idle, test_mode, cpu_rst_b, isp_env, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] mem_addr, mem_wdata, exec_addr, mem_rdata, arr_wdata, arr_rdata, boot_vector;
	logic [1:0] mem_be, arr_be;
	logic [11:0] arr_addr;
	logic [2:0] env_sel;
	ispf_pkg::ispf_arr_ctl_s arr_ctl, rd_ctl;
	int fail_count, tests_run, lat, wlat;

	ispf_ctrl #(.PAGE_ERASE_CYC(PE_CYC), .MASS_ERASE_CYC(ME_CYC), .PROG_KEY(KEY)) dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.mem_sel(mem_sel), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_be(mem_be),
		.mem_wdata(mem_wdata), .exec_addr(exec_addr), .mem_ready(mem_ready), .mem_err(mem_err),
		.mem_rdata(mem_rdata), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_be(arr_be),
		.arr_ctl(arr_ctl), .arr_rdata(arr_rdata), .arr_idle(arr_idle), .env_sel(env_sel),
		.test_mode(test_mode), .cpu_rst_b(cpu_rst_b), .isp_env(isp_env),
		.boot_vector(boot_vector));
	ispf_array_model u_array (.sys_clk(sys_clk), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
		.arr_be(arr_be), .arr_ctl(arr_ctl), .arr_rdata(arr_rdata), .arr_idle(arr_idle));

	always #5 sys_clk = ~sys_clk;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task mem(input logic wr, input logic [15:0] a, input logic [1:0] be, input logic [15:0] d);
		@(posedge sys_clk);
		mem_sel <= 1'b1;
		mem_wr <= wr;
		mem_addr <= a;
		mem_be <= be;
		mem_wdata <= d;
		lat = 0;
		do begin
			@(posedge sys_clk);
			lat++;
			if (arr_ctl.rd === 1'b1) rd_ctl = arr_ctl;
		end while (mem_ready !== 1'b1);
		rd = {16'h0000, mem_rdata};
		err = mem_err;
		mem_sel <= 1'b0;
		mem_wr <= 1'b0;
	endtask
	task wait_idle;
		for (int i = 0; i < 3000; i++) begin
			apb(1'b0, ispf_pkg::OFS_STAT, 32'h0);
			if (rd[0] === 1'b0) break;
		end
		check(32'(rd[0]), 32'h0);
		@(posedge sys_clk);
	endtask
	task do_reset;
		@(posedge sys_clk);
		rst_b <= 1'b0;
		@(posedge sys_clk);
		#1;
		check(32'(arr_ctl), 32'h0);
		check(32'(cpu_rst_b), 32'h0);
		repeat (15) @(posedge sys_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(posedge sys_clk);
			if (cpu_rst_b === 1'b1) break;
		end
		check(32'(cpu_rst_b), 32'h1);
	endtask
	task keyed_write(input logic [15:0] a, input logic [1:0] be, input logic [15:0] d);
		apb(1'b1, ispf_pkg::OFS_PKEY, {24'h0, KEY});
		mem(1'b1, a, be, d);
	endtask

	task t_reset;
		apb(1'b0, ispf_pkg::OFS_LOCK, 32'h0);
		check(rd, 32'h000000C9);
		apb(1'b0, ispf_pkg::OFS_STAT, 32'h0);
		check(32'(rd[3:0]), 32'h0000000C);
		check(32'(boot_vector), 32'(ispf_pkg::ISP_VECTOR));
		apb(1'b0, ispf_pkg::OFS_CFG2, 32'h0);
		check(rd & 32'h0000E3FF, 32'h0000E3FF);
		apb(1'b0, ispf_pkg::OFS_SEC, 32'h0);
		check(rd, 32'h000000FF);
		apb(1'b0, ispf_pkg::OFS_CFG1, 32'h0);
		check(rd & 32'h0000007F, 32'h0000007F);
		apb(1'b0, 8'h1C, 32'h0);
		check(32'(err), 32'h1);
		$display("test reset done");
	endtask
	task t_lock;
		apb(1'b1, ispf_pkg::OFS_LOCK, 32'h0);
		apb(1'b0, ispf_pkg::OFS_LOCK, 32'h0);
		check(rd, 32'h0);
		mem(1'b1, 16'hE600, 2'h3, 16'h1234);
		check(32'(err), 32'h1);
		keyed_write(16'hE5F0, 2'h3, 16'h0F0F);
		check(32'(err), 32'h0);
		wait_idle;
		apb(1'b1, ispf_pkg::OFS_LOCK, 32'h000000C9);
		mem(1'b1, 16'hE600, 2'h3, 16'h1234);
		check(32'(err), 32'h0);
		wait_idle;
		mem(1'b1, 16'hE602, 2'h3, 16'h5678);
		check(32'(err), 32'h0);
		wait_idle;
		mem(1'b0, 16'hE600, 2'h3, 16'h0);
		check(rd, 32'h00001234);
		mem(1'b0, 16'hE5F0, 2'h3, 16'h0);
		check(rd, 32'h00000F0F);
		$display("test lock done");
	endtask
	task t_prog;
		mem(1'b1, 16'hE010, 2'h3, 16'hABCD);
		check(32'(err), 32'h1);
		apb(1'b1, ispf_pkg::OFS_PKEY, {24'h0, KEY});
		apb(1'b0, ispf_pkg::OFS_STAT, 32'h0);
		check(32'(rd[1:0]), 32'h2);
		mem(1'b1, 16'hE010, 2'h3, 16'hABCD);
		check(32'(err), 32'h0);
		mem(1'b0, 16'hE000, 2'h3, 16'h0);
		check({rd[15:0], 15'h0, err}, 32'h1);
		mem(1'b0, 16'hE600, 2'h3, 16'h0);
		check({rd[15:0], 15'h0, err}, 32'h1);
		apb(1'b0, ispf_pkg::OFS_STAT, 32'h0);
		check(32'(rd[0]), 32'h1);
		wait_idle;
		check(32'(u_array.last_len), 32'(ispf_pkg::PROG_CYC));
		mem(1'b0, 16'hE010, 2'h3, 16'h0);
		check(rd, 32'h0000ABCD);
		mem(1'b1, 16'hE012, 2'h3, 16'h0);
		check(32'(err), 32'h1);
		mem(1'b0, 16'hF000, 2'h3, 16'h0);
		check({rd[15:0], 15'h0, err}, 32'h1);
		$display("test program done");
	endtask
	task t_erase;
		keyed_write(16'hE018, 2'h3, 16'h0000);
		wait_idle;
		apb(1'b1, ispf_pkg::OFS_CTRL, 32'h1);
		keyed_write(16'hE012, 2'h3, 16'h0000);
		check(32'(err), 32'h0);
		wait_idle;
		check(32'(u_array.last_len), 32'(PE_CYC));
		mem(1'b0, 16'hE010, 2'h3, 16'h0);
		check(rd, 32'h0000FFFF);
		mem(1'b0, 16'hE018, 2'h3, 16'h0);
		check(rd, 32'h00000000);
		apb(1'b1, ispf_pkg::OFS_CTRL, 32'h0);
		$display("test erase done");
	endtask
	task t_mass;
		keyed_write(16'hE020, 2'h3, 16'h0000);
		wait_idle;
		apb(1'b1, ispf_pkg::OFS_CTRL, 32'h2);
		keyed_write(16'hE000, 2'h3, 16'h0000);
		check(32'(err), 32'h1);
		@(posedge sys_clk);
		test_mode <= 1'b1;
		keyed_write(16'hE001, 2'h2, 16'h0000);
		wait_idle;
		mem(1'b0, 16'hE020, 2'h3, 16'h0);
		check(rd, 32'h0000FF00);
		keyed_write(16'hE000, 2'h3, 16'h0000);
		check(32'(err), 32'h0);
		wait_idle;
		check(32'(u_array.last_len), 32'(ME_CYC));
		mem(1'b0, 16'hE018, 2'h3, 16'h0);
		check(rd, 32'h0000FFFF);
		apb(1'b1, ispf_pkg::OFS_CTRL, 32'h0);
		test_mode <= 1'b0;
		$display("test mass erase done");
	endtask
	task t_read;
		mem(1'b1, 16'hF000, 2'h3, 16'h0);
		wlat = lat;
		mem(1'b0, 16'hE018, 2'h3, 16'h0);
		check(32'(lat), 32'(wlat + 1));
		check(32'(rd_ctl.sa_half), 32'h1);
		apb(1'b1, ispf_pkg::OFS_CTRL, 32'h8);
		mem(1'b0, 16'hE018, 2'h3, 16'h0);
		check(32'(lat), 32'(wlat + 2));
		check(32'(rd_ctl.sa_en), 32'h1);
		apb(1'b1, ispf_pkg::OFS_CTRL, 32'h4);
		mem(1'b0, 16'hE018, 2'h3, 16'h0);
		check(32'(rd_ctl.sa_en), 32'h1);
		$display("test read done");
	endtask
	task t_abort;
		apb(1'b1, ispf_pkg::OFS_CTRL, 32'h1);
		keyed_write(16'hE028, 2'h3, 16'h0000);
		repeat (3) @(posedge sys_clk);
		do_reset;
		apb(1'b0, ispf_pkg::OFS_CTRL, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, ispf_pkg::OFS_LOCK, 32'h0);
		check(rd, 32'h000000C9);
		$display("test abort done");
	endtask

	initial begin
		sys_clk = 1'b0;
		rst_b = 1'b0;
		{psel, penable, pwrite, mem_sel, mem_wr, test_mode} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		// Writes are issued as if fetched from system RAM, outside the array.
		{mem_addr, mem_wdata, exec_addr} = 48'h0;
		mem_be = 2'h0;
		env_sel = 3'h7;
		fail_count = 0;
		tests_run = 0;
		do_reset;
		t_reset;
		t_lock;
		t_prog;
		t_erase;
		t_mass;
		t_read;
		t_abort;
		tally_and_finish;
	end
	initial begin
		#1000000;
		fail_count++;
		$display("ERROR %0t: watchdog expired", $time);
		tally_and_finish;
	end
endmodule // tb_top
